// ==== nvs_dev.sv ====
// Device end: SPI slave front end of a 512K x 8 nonvolatile RAM.
// Assumes the link clock is well below core_clk / 4 so edges can be sampled.
`timescale 1ns/1ns
module nvs_dev
	import nvs_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic rst_n,
	nvs_link_if.dev   link,
	output logic      ready,
	output logic      busy
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		NVS_D_IDLE = 5'b00001,
		NVS_D_OPC  = 5'b00010,
		NVS_D_ADR  = 5'b00100,
		NVS_D_DAT  = 5'b01000,
		NVS_D_DROP = 5'b10000
	} nvs_dst_e;

	typedef struct packed {
		logic [2:0]          cs_sync;
		logic [2:0]          sck_sync;
		logic [1:0]          si_sync;
		nvs_dst_e            st;
		logic [7:0]          op;
		logic [7:0]          sh;
		logic [2:0]          bitc;
		logic [1:0]          bytec;
		logic [NVS_ADDR_W-1:0] addr;
		logic [7:0]          status;
		logic [7:0]          tx;
		logic                so;
		logic                oe;
		logic                ready;
		logic                busy;
		logic [18:0]         pu_cnt;
	} nvs_dev_s;

	nvs_dev_s state_reg;
	nvs_dev_s state_next;
	logic [7:0] mem [0:NVS_MEM_DEPTH-1];
	logic       wr_en;
	logic [NVS_ADDR_W-1:0] wr_addr;
	logic [7:0] wr_data;

	function automatic logic nvs_is_read(input logic [7:0] op);
		return (op == NVS_OP_RMEM) || (op == NVS_OP_FRMEM);
	endfunction : nvs_is_read

	function automatic logic nvs_has_addr(input logic [7:0] op);
		return nvs_is_read(op) || (op == NVS_OP_WMEM);
	endfunction : nvs_has_addr

	// Block protection: upper quarter, upper half, or all.
	function automatic logic nvs_protected(input logic [1:0] bp,
	                                       input logic [NVS_ADDR_W-1:0] a);
		unique case (bp)
			2'h0: return 1'b0;
			2'h1: return a[18:17] == 2'h3;
			2'h2: return a[18];
			default: return 1'b1;
		endcase
	endfunction : nvs_protected

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic cs_n;
		logic rise;
		logic fall;
		logic cs_fall;
		logic [7:0] nsh;
		cs_n = 1'b1;
		rise = 1'b0;
		fall = 1'b0;
		cs_fall = 1'b0;
		nsh = 8'h00;
		state_next = state_reg;
		wr_en = 1'b0;
		wr_addr = state_reg.addr;
		wr_data = 8'h00;
		state_next.cs_sync  = {state_reg.cs_sync[1:0], link.cs_n};
		state_next.sck_sync = {state_reg.sck_sync[1:0], link.sck};
		state_next.si_sync  = {state_reg.si_sync[0], link.si};
		cs_n = state_reg.cs_sync[1];
		cs_fall = state_reg.cs_sync[2] && !cs_n;
		// A rising edge seen at select time in mode 3 cannot occur, since
		// the level is already high; the first counted rise follows a fall.
		rise = state_reg.sck_sync[1] && !state_reg.sck_sync[2];
		fall = !state_reg.sck_sync[1] && state_reg.sck_sync[2];
		nsh = {state_reg.sh[6:0], state_reg.si_sync[1]};

		if (state_reg.pu_cnt != 19'(POWERUP_ACCESS_CYC))
			state_next.pu_cnt = state_reg.pu_cnt + 19'h00001;
		else
			state_next.ready = 1'b1;

		if (cs_n || !state_reg.ready) begin
			state_next.st = NVS_D_IDLE;
			state_next.bitc = 3'h0;
			state_next.bytec = 2'h0;
			state_next.oe = 1'b0;
			// Write enable drops at deselect after a WDIS, WSTAT or WMEM command.
			if (state_reg.st != NVS_D_IDLE && (state_reg.op == NVS_OP_WDIS
			    || state_reg.op == NVS_OP_WSTAT || state_reg.op == NVS_OP_WMEM))
				state_next.status[1] = 1'b0;
		end else begin
			if (cs_fall || state_reg.st == NVS_D_IDLE) begin
				// Mode follows the clock level here; sampling starts on rises.
				state_next.st = NVS_D_OPC;
				state_next.bitc = 3'h0;
			end
			if (rise && state_reg.st != NVS_D_IDLE && state_reg.st != NVS_D_DROP) begin
				state_next.sh = nsh;
				state_next.bitc = state_reg.bitc + 3'h1;
				if (state_reg.bitc == 3'h7) begin
					unique case (state_reg.st)
						NVS_D_OPC: begin
							state_next.op = nsh;
							if (!nvs_op_known(nsh))
								state_next.st = NVS_D_DROP;
							else if (nvs_has_addr(nsh))
								state_next.st = NVS_D_ADR;
							else begin
								state_next.st = NVS_D_DAT;
								if (nsh == NVS_OP_WEN)
									state_next.status[1] = 1'b1;
								if (nsh == NVS_OP_WDIS)
									state_next.status[1] = 1'b0;
								state_next.tx = state_reg.status;
							end
						end
						NVS_D_ADR: begin
							state_next.bytec = state_reg.bytec + 2'h1;
							// The top five of 24 bits fall off the 19-bit field.
							state_next.addr = {state_reg.addr[10:0], nsh};
							if (state_reg.bytec == 2'(NVS_ADDR_BYTES - 1)) begin
								state_next.st = NVS_D_DAT;
								state_next.tx = mem[{state_reg.addr[10:0], nsh}];
							end
						end
						NVS_D_DAT: begin
							if (state_reg.op == NVS_OP_WSTAT && state_reg.status[1])
								state_next.status = (state_reg.status & ~NVS_STATUS_WMSK)
								                    | (nsh & NVS_STATUS_WMSK);
							if (state_reg.op == NVS_OP_WMEM) begin
								// Each byte lands at once, so no busy state exists.
								wr_en = state_reg.status[1]
								        && !nvs_protected(state_reg.status[3:2],
								                          state_reg.addr);
								wr_data = nsh;
								state_next.addr = state_reg.addr + 19'h00001;
							end
							if (nvs_is_read(state_reg.op)) begin
								state_next.addr = state_reg.addr + 19'h00001;
								state_next.tx = mem[state_reg.addr + 19'h00001];
							end
						end
						default: ;
					endcase
				end
			end
			// Output changes only on falls, and only for read-type commands.
			if (fall && state_reg.st == NVS_D_DAT
			    && (nvs_is_read(state_reg.op) || state_reg.op == NVS_OP_RSTAT)) begin
				state_next.oe = 1'b1;
				state_next.so = state_reg.tx[3'h7 - state_reg.bitc];
			end
			if (state_reg.st == NVS_D_DROP)
				state_next.oe = 1'b0;
		end

		if (!rst_n) begin
			state_next = '0;
			state_next.cs_sync = 3'h7;
			state_next.st = NVS_D_IDLE;
			state_next.status = NVS_STATUS_RST;
			wr_en = 1'b0;
		end
		// Busy is registered so the output comes straight from a flip-flop.
		state_next.busy = state_next.st != NVS_D_IDLE;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		state_reg <= state_next;
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	assign link.so_o  = state_reg.so;
	assign link.so_oe = state_reg.oe;
	assign ready      = state_reg.ready;
	assign busy       = state_reg.busy;

endmodule : nvs_dev

// ==== nvs_link_chk.sv ====
// Checker for the link between the memory front end and its bus master.
// Assumes one core_clk domain; the bench wires in the interface signals by name.
`timescale 1ns/1ns
module nvs_link_chk
	import nvs_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so_o,
	input wire logic so_oe
);
	// ------------------------------------------------------------
	// Opcode capture and power-up count
	// ------------------------------------------------------------
	logic [12:0] up_cnt_reg;
	logic [7:0]  op_reg;
	logic [3:0]  bit_cnt_reg;
	logic        sck_d_reg;
	logic        bad_op_reg;

	// The count saturates so that a long run never wraps back into the quiet window.
	always_ff @(posedge core_clk) begin
		sck_d_reg <= sck;
		if (!rst_n) begin
			up_cnt_reg  <= '0;
			op_reg      <= '0;
			bit_cnt_reg <= '0;
			bad_op_reg  <= 1'b0;
		end else begin
			if (up_cnt_reg != 13'h1FFF) up_cnt_reg <= up_cnt_reg + 13'h1;
			if (cs_n) begin
				bit_cnt_reg <= '0;
				bad_op_reg  <= 1'b0;
			end else if (sck && !sck_d_reg && bit_cnt_reg < 4'h8) begin
				op_reg      <= {op_reg[6:0], si};
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end else if (bit_cnt_reg == 4'h8) begin
				bad_op_reg <= !(op_reg inside {8'h06, 8'h04, 8'h05, 8'h01, 8'h02, 8'h03,
					8'h0B, 8'h42, 8'h4B, 8'h9F, 8'h4C, 8'hC2, 8'hC3, 8'hBA, 8'hB9});
			end
		end
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_deselect_tristate: assert property (cs_n [*5] |-> !so_oe)
		else $error("output driven while deselected");
	a_deselect_release: assert property ($rose(cs_n) |-> ##[1:4] !so_oe)
		else $error("output kept after deselect");
	a_opcode_quiet: assert property ($fell(cs_n) |-> !so_oe [*8])
		else $error("output driven during opcode");
	a_launch_on_low: assert property (so_oe && $past(so_oe) && $changed(so_o) |-> !sck)
		else $error("output changed while clock high");
	a_hold_on_high: assert property (so_oe && $past(so_oe) && sck && $past(sck) |-> $stable(so_o))
		else $error("output moved during high phase");
	a_bad_op_silent: assert property (bad_op_reg && !cs_n |-> !so_oe)
		else $error("output driven after bad opcode");
	a_powerup_quiet: assert property (up_cnt_reg < POWERUP_ACCESS_CYC |-> !so_oe)
		else $error("output driven before power-up delay");
	a_frame_gap: assert property ($rose(cs_n) |-> cs_n [*4])
		else $error("select gap too short");
	a_si_steady: assert property (!cs_n && $rose(sck) |-> $stable(si))
		else $error("input changed at rising clock");

	c_mode3_start: cover property ($fell(cs_n) && sck);
	c_read_drive: cover property ($rose(so_oe));
	c_bad_op: cover property ($rose(bad_op_reg));
endmodule : nvs_link_chk

// ==== nvs_link_if.sv ====
// SPI link between the memory front end and its single bus master.
// Assumes the bench resolves the shared data line from the enable.
`timescale 1ns/1ns
interface nvs_link_if;
	logic cs_n;
	logic sck;
	logic si;
	logic so_o;
	logic so_oe;

	modport dev (input cs_n, input sck, input si, output so_o, output so_oe);
	modport mst (output cs_n, output sck, output si, input so_o, input so_oe);
endinterface : nvs_link_if

// ==== nvs_mst.sv ====
// Master end: issues one SPI command frame per user request.
// Assumes the device end samples the link with core_clk as well.
`timescale 1ns/1ns
module nvs_mst
	import nvs_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	nvs_link_if.mst         link,
	input  wire logic       req,
	input  wire logic       mode3,
	input  wire logic [5:0] nbytes,
	input  wire logic [7:0] tx_byte,
	output logic            tx_take,
	output logic [7:0]      rx_byte,
	output logic            rx_valid,
	output logic            idle
);

	typedef enum logic [2:0] {
		NVS_M_IDLE = 3'b001,
		NVS_M_RUN  = 3'b010,
		NVS_M_END  = 3'b100
	} nvs_mst_e;

	typedef struct packed {
		nvs_mst_e   st;
		logic       cs_n;
		logic       sck;
		logic       cpol;
		logic [7:0] sh;
		logic [2:0] bitc;
		logic [5:0] left;
		logic [3:0] div;
		logic [7:0] rsh;
		logic       more;
		logic       take;
		logic       rxv;
		logic [7:0] rx;
	} nvs_mst_s;

	nvs_mst_s state_reg;
	nvs_mst_s state_next;

	always_comb begin
		state_next = state_reg;
		state_next.take = 1'b0;
		state_next.rxv = 1'b0;
		unique case (state_reg.st)
			NVS_M_IDLE: begin
				state_next.sck = mode3;
				state_next.cpol = mode3;
				if (req && nbytes != 6'h00) begin
					state_next.st = NVS_M_RUN;
					state_next.cs_n = 1'b0;
					state_next.sh = tx_byte;
					state_next.take = 1'b1;
					state_next.left = nbytes;
					state_next.bitc = 3'h0;
					state_next.div = 4'h0;
					state_next.more = 1'b0;
				end
			end
			NVS_M_RUN: begin
				state_next.div = state_reg.div + 4'h1;
				if (state_reg.div == 4'(NVS_SCK_HALF_CYC - 1)) begin
					state_next.div = 4'h0;
					state_next.sck = !state_reg.sck;
					if (!state_reg.sck) begin
						// Rising edge: the device samples si, the master samples so.
						// So comes from a register on this clock, so it needs no sync.
						state_next.rsh = {state_reg.rsh[6:0], link.so_o};
						state_next.bitc = state_reg.bitc + 3'h1;
						if (state_reg.bitc == 3'h7) begin
							state_next.rx = {state_reg.rsh[6:0], link.so_o};
							state_next.rxv = 1'b1;
							state_next.left = state_reg.left - 6'h01;
							state_next.more = state_reg.left != 6'h01;
							if (state_reg.left == 6'h01)
								state_next.st = NVS_M_END;
						end
					end else if (state_reg.bitc != 3'h0) begin
						// Falling edge: si moves only while the clock goes low.
						state_next.sh = {state_reg.sh[6:0], 1'b0};
					end else if (state_reg.more) begin
						// The leading fall of mode 3 has no byte behind it.
						state_next.sh = tx_byte;
						state_next.take = 1'b1;
						state_next.more = 1'b0;
					end
				end
			end
			NVS_M_END: begin
				state_next.div = state_reg.div + 4'h1;
				if (state_reg.div == 4'(NVS_SCK_HALF_CYC - 1)) begin
					state_next.sck = state_reg.cpol;
					state_next.cs_n = 1'b1;
					state_next.st = NVS_M_IDLE;
				end
			end
			default: state_next.st = NVS_M_IDLE;
		endcase
		if (!rst_n) begin
			state_next = '0;
			state_next.st = NVS_M_IDLE;
			state_next.cs_n = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		state_reg <= state_next;
	end

	assign link.cs_n = state_reg.cs_n;
	assign link.sck  = state_reg.sck;
	assign link.si   = state_reg.sh[7];
	assign tx_take   = state_reg.take;
	assign rx_byte   = state_reg.rx;
	assign rx_valid  = state_reg.rxv;
	assign idle      = state_reg.st == NVS_M_IDLE;

endmodule : nvs_mst

// ==== nvs_pkg.sv ====
// Package for the serial nonvolatile RAM front end and its bus master.
// Assumes both ends run on core_clk and the link clock is slow against it.
package nvs_pkg;

	// ----------------------------------------------------------------
	// Geometry and framing
	// ----------------------------------------------------------------
	localparam int          NVS_ADDR_W      = 19;
	localparam int          NVS_MEM_DEPTH   = 524288;
	localparam int          NVS_BYTE_W      = 8;
	localparam int          NVS_ADDR_BYTES  = 3;
	localparam int          NVS_ADDR_SKIP   = 5;
	localparam logic [7:0]  NVS_STATUS_RST  = 8'h40;
	localparam logic [7:0]  NVS_STATUS_WMSK = 8'h8C;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] NVS_OP_WEN   = 8'h06;
	localparam logic [7:0] NVS_OP_WDIS  = 8'h04;
	localparam logic [7:0] NVS_OP_RSTAT = 8'h05;
	localparam logic [7:0] NVS_OP_WSTAT = 8'h01;
	localparam logic [7:0] NVS_OP_WMEM  = 8'h02;
	localparam logic [7:0] NVS_OP_RMEM  = 8'h03;
	localparam logic [7:0] NVS_OP_FRMEM = 8'h0B;
	localparam logic [7:0] NVS_OP_SSW   = 8'h42;
	localparam logic [7:0] NVS_OP_SSR   = 8'h4B;
	localparam logic [7:0] NVS_OP_RID   = 8'h9F;
	localparam logic [7:0] NVS_OP_RUID  = 8'h4C;
	localparam logic [7:0] NVS_OP_WSN   = 8'hC2;
	localparam logic [7:0] NVS_OP_RSN   = 8'hC3;
	localparam logic [7:0] NVS_OP_DPD   = 8'hBA;
	localparam logic [7:0] NVS_OP_HIB   = 8'hB9;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CORE_CLK_NS          = 100;
	localparam int POWERUP_ACCESS_DELAY_US = 450;
	localparam int POWERUP_ACCESS_CYC   =
		(POWERUP_ACCESS_DELAY_US * 1000 + CORE_CLK_NS - 1) / CORE_CLK_NS;
	localparam int NVS_SCK_HALF_CYC     = 4;

	function automatic logic nvs_op_known(input logic [7:0] op);
		unique case (op)
			NVS_OP_WEN, NVS_OP_WDIS, NVS_OP_RSTAT, NVS_OP_WSTAT, NVS_OP_WMEM,
			NVS_OP_RMEM, NVS_OP_FRMEM, NVS_OP_SSW, NVS_OP_SSR, NVS_OP_RID,
			NVS_OP_RUID, NVS_OP_WSN, NVS_OP_RSN, NVS_OP_DPD, NVS_OP_HIB:
				return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : nvs_op_known

endpackage : nvs_pkg

// ==== spi_nvram_slave_front_end_test.sv ====
// Bench for the memory front end: device and master joined by the link.
// Assumes the package power-up delay is short enough to wait out in full.
`timescale 1ns/1ns
module spi_nvram_slave_front_end_test;
	import nvs_pkg::*;
	logic        core_clk;
	logic        rst_n;
	logic        req;
	logic        mode3;
	logic [5:0]  nbytes;
	logic [7:0]  tx_byte;
	logic        tx_take;
	logic [7:0]  rx_byte;
	logic        rx_valid;
	logic        idle;
	logic        ready;
	logic        busy;
	int          mismatches;
	int          checks_done;
	logic [7:0]  last_rx;
	logic [7:0]  op_seen;
	logic [7:0]  fr [6];
	logic        drove;
	logic [23:0] wa [3] = '{24'hF80000, 24'h07FFFF, 24'h012345};
	logic [23:0] ra [3] = '{24'h000000, 24'h07FFFF, 24'hA92345};
	logic [7:0]  wd [3] = '{8'hA5, 8'h3C, 8'h81};
	logic [7:0]  bad [3] = '{8'hFF, 8'h00, 8'h07};

	nvs_link_if link ();
	nvs_dev nvs_dev_inst (.core_clk(core_clk), .rst_n(rst_n), .link(link), .ready(ready),
		.busy(busy));
	nvs_mst nvs_mst_inst (.core_clk(core_clk), .rst_n(rst_n), .link(link), .req(req),
		.mode3(mode3), .nbytes(nbytes), .tx_byte(tx_byte), .tx_take(tx_take),
		.rx_byte(rx_byte), .rx_valid(rx_valid), .idle(idle));
	nvs_link_chk nvs_link_chk_inst (.core_clk(core_clk), .rst_n(rst_n), .cs_n(link.cs_n),
		.sck(link.sck), .si(link.si), .so_o(link.so_o), .so_oe(link.so_oe));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic end_of_test();
		if (mismatches == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// One frame of n bytes; the wire is watched as the device sees it.
	task automatic xfer(input int n, input logic m3);
		int i;
		int k;
		int rises;
		logic ps;
		logic pc;
		logic lvl;
		i = 0;
		rises = 0;
		drove = 1'b0;
		op_seen = '0;
		lvl = 1'bx;
		mode3 <= m3;
		repeat (4) @(posedge core_clk);
		check("idle busy", 8'h00, {7'h0, busy});
		ps = link.sck;
		pc = link.cs_n;
		nbytes <= 6'(n);
		tx_byte <= fr[0];
		req <= 1'b1;
		for (k = 0; k < 4000; k++) begin
			@(posedge core_clk);
			if (tx_take === 1'b1) begin
				req <= 1'b0;
				i++;
				if (i < n) tx_byte <= fr[i];
			end
			if (rx_valid === 1'b1) last_rx = rx_byte;
			if (pc && !link.cs_n) lvl = link.sck;
			if (!link.cs_n && link.sck && !ps) begin
				rises++;
				if (rises <= 8) op_seen = {op_seen[6:0], link.si};
			end
			if (link.so_oe === 1'b1) drove = 1'b1;
			ps = link.sck;
			pc = link.cs_n;
			if (i > 0 && idle === 1'b1 && link.cs_n === 1'b1) break;
		end
		if (k == 4000) begin
			mismatches++;
			end_of_test();
		end
		check("mode level", {7'h0, m3}, {7'h0, lvl});
		check("opcode on wire", fr[0], op_seen);
		check("clock rises", 8'(8 * n), 8'(rises));
	endtask : xfer

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	initial begin : main
		int t;
		rst_n = 1'b0;
		req = 1'b0;
		mode3 = 1'b0;
		nbytes = '0;
		tx_byte = '0;
		mismatches = 0;
		checks_done = 0;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		for (t = 0; t < 6000 && ready !== 1'b1; t++) @(posedge core_clk);
		check("ready", 8'h01, {7'h0, ready});
		if (ready !== 1'b1) end_of_test();
		fr = '{8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		xfer(2, 1'b0);
		check("status", NVS_STATUS_RST, last_rx);
		check("read drive", 8'h01, {7'h0, drove});
		fr[0] = 8'h06;
		xfer(1, 1'b1);
		fr[0] = 8'h05;
		xfer(2, 1'b1);
		check("status wel", NVS_STATUS_RST | 8'h02, last_rx);
		fr[0] = 8'h04;
		fr[1] = 8'h06;
		xfer(2, 1'b0);
		fr = '{8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		xfer(2, 1'b0);
		check("one opcode", NVS_STATUS_RST, last_rx);
		for (int j = 0; j < 3; j++) begin
			fr[0] = 8'h06;
			xfer(1, j[0]);
			fr = '{8'h02, wa[j][23:16], wa[j][15:8], wa[j][7:0], wd[j], 8'h00};
			xfer(5, j[0]);
			check("write drive", 8'h00, {7'h0, drove});
			fr = '{8'h03, ra[j][23:16], ra[j][15:8], ra[j][7:0], 8'h00, 8'h00};
			xfer(5, !j[0]);
			check("read back", wd[j], last_rx);
		end
		for (int j = 0; j < 3; j++) begin
			fr = '{bad[j], 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
			xfer(3, j[0]);
			check("bad opcode drive", 8'h00, {7'h0, drove});
		end
		fr = '{8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		xfer(2, 1'b1);
		check("status after", NVS_STATUS_RST, last_rx);
		end_of_test();
	end
endmodule : spi_nvram_slave_front_end_test
